// file: core/apc_pad_gate.sv
// Purpose: Per-channel gating of port pad controls by the analog mask.
// Assumes: Port side controls come from logic on the same clock.
// Notes:   Every gated output is registered, adding one cycle of latency.

`timescale 1ns/10ps

module apc_pad_gate (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    apc_pad_if.gate   pad
);

    // ------------------------------------------------------------------
    // Per-channel gating
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < apc_pkg::APC_NUM_CH; ch++) begin : g_ch
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                pad.pad_out[ch] <= 1'b0;
                pad.pad_oe[ch]  <= 1'b0;
                pad.pad_pue[ch] <= 1'b0;
                pad.pad_ibe[ch] <= 1'b1;
                pad.port_rd[ch] <= 1'b0;
            end else begin
                pad.pad_out[ch] <= pad.port_out[ch] & ~pad.disable_mask[ch];
                pad.pad_oe[ch]  <= pad.port_oe[ch] & ~pad.disable_mask[ch];
                pad.pad_pue[ch] <= pad.port_pue[ch] & ~pad.disable_mask[ch];
                pad.pad_ibe[ch] <= ~pad.disable_mask[ch];
                pad.port_rd[ch] <= pad.pad_sync[ch] & ~pad.disable_mask[ch];
            end
        end
    end

endmodule // apc_pad_gate

// file: core/apc_pad_if.sv
// Purpose: Carries port controls and gated pad controls between modules.
// Assumes: All signals belong to the system clock domain.
// Notes:   The control end drives the mask and port side values.

`timescale 1ns/10ps

interface apc_pad_if;

    apc_pkg::apc_chan_t disable_mask;
    apc_pkg::apc_chan_t port_out;
    apc_pkg::apc_chan_t port_oe;
    apc_pkg::apc_chan_t port_pue;
    apc_pkg::apc_chan_t pad_sync;
    apc_pkg::apc_chan_t pad_out;
    apc_pkg::apc_chan_t pad_oe;
    apc_pkg::apc_chan_t pad_pue;
    apc_pkg::apc_chan_t pad_ibe;
    apc_pkg::apc_chan_t port_rd;

    modport ctrl (
        output disable_mask,
        output port_out,
        output port_oe,
        output port_pue,
        output pad_sync,
        input  pad_out,
        input  pad_oe,
        input  pad_pue,
        input  pad_ibe,
        input  port_rd
    );

    modport gate (
        input  disable_mask,
        input  port_out,
        input  port_oe,
        input  port_pue,
        input  pad_sync,
        output pad_out,
        output pad_oe,
        output pad_pue,
        output pad_ibe,
        output port_rd
    );

endinterface // apc_pad_if

// file: core/apc_pin_ctrl.sv
// Purpose: Analog pin control registers and the pad gating they steer.
// Assumes: Plain register port with one-cycle strobes, read data one
//          cycle after the read strobe; port controls on i_clk.
// Notes:   Pad levels arrive from pins and pass two flip-flops first.
//
// The implementer's own choices: the plain strobed port and the address map.

`timescale 1ns/10ps

module apc_pin_ctrl (
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    input  wire apc_pkg::apc_addr_t i_addr,
    input  wire apc_pkg::apc_byte_t i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic [7:0]              o_rdata,
    input  wire apc_pkg::apc_chan_t i_port_out,
    input  wire apc_pkg::apc_chan_t i_port_oe,
    input  wire apc_pkg::apc_chan_t i_port_pue,
    input  wire apc_pkg::apc_chan_t i_pad_in,
    output apc_pkg::apc_chan_t      o_pad_out,
    output apc_pkg::apc_chan_t      o_pad_oe,
    output apc_pkg::apc_chan_t      o_pad_pue,
    output apc_pkg::apc_chan_t      o_pad_ibe,
    output apc_pkg::apc_chan_t      o_port_rd,
    output apc_pkg::apc_chan_t      o_analog_sel
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    apc_pkg::apc_byte_t dis_ch0_7_q;
    apc_pkg::apc_byte_t dis_ch8_15_q;
    apc_pkg::apc_byte_t dis_ch16_23_q;
    apc_pkg::apc_chan_t disable_mask;
    apc_pkg::apc_chan_t pad_meta_q;
    apc_pkg::apc_chan_t pad_sync_q;
    apc_pkg::apc_chan_t analog_sel_q;
    apc_pkg::apc_byte_t rdata_d;
    apc_pkg::apc_byte_t rdata_q;
    logic               wr_reg0;
    logic               wr_reg1;
    logic               wr_reg2;

    apc_pad_if pad ();

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    // Writes to read-only or unmapped offsets are dropped silently.
    assign wr_reg0 = i_wr && (i_addr == apc_pkg::APC_OFS_DISABLE_CH0_7);
    assign wr_reg1 = i_wr && (i_addr == apc_pkg::APC_OFS_DISABLE_CH8_15);
    assign wr_reg2 = i_wr && (i_addr == apc_pkg::APC_OFS_DISABLE_CH16_23);

    // ------------------------------------------------------------------
    // Pin control registers
    // ------------------------------------------------------------------
    // cleared at reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dis_ch0_7_q <= apc_pkg::APC_RST_DISABLE;
        end else if (wr_reg0) begin
            dis_ch0_7_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dis_ch8_15_q <= apc_pkg::APC_RST_DISABLE;
        end else if (wr_reg1) begin
            dis_ch8_15_q <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dis_ch16_23_q <= apc_pkg::APC_RST_DISABLE;
        end else if (wr_reg2) begin
            dis_ch16_23_q <= i_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Channel mapping
    // ------------------------------------------------------------------
    // channels 0 to 23, eight per register
    assign disable_mask[apc_pkg::APC_CH_BASE_REG0 +: apc_pkg::APC_REG_W] =
        dis_ch0_7_q;
    assign disable_mask[apc_pkg::APC_CH_BASE_REG1 +: apc_pkg::APC_REG_W] =
        dis_ch8_15_q;
    assign disable_mask[apc_pkg::APC_CH_BASE_REG2 +: apc_pkg::APC_REG_W] =
        dis_ch16_23_q;

    // The converter's channel multiplexer sees the same mask, registered
    // so that it lines up with the pad gating below.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            analog_sel_q <= apc_pkg::APC_RST_CHAN;
        end else begin
            analog_sel_q <= disable_mask;
        end
    end

    // ------------------------------------------------------------------
    // Pad input synchroniser
    // ------------------------------------------------------------------
    // Pins are asynchronous to i_clk; the first stage feeds only the
    // second, and nothing else looks at it.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pad_meta_q <= apc_pkg::APC_RST_CHAN;
            pad_sync_q <= apc_pkg::APC_RST_CHAN;
        end else begin
            pad_meta_q <= i_pad_in;
            pad_sync_q <= pad_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Pad gating
    // ------------------------------------------------------------------
    assign pad.disable_mask = disable_mask;
    assign pad.port_out     = i_port_out;
    assign pad.port_oe      = i_port_oe;
    assign pad.port_pue     = i_port_pue;
    assign pad.pad_sync     = pad_sync_q;

    apc_pad_gate u_gate (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .pad       (pad.gate)
    );

    assign o_pad_out    = pad.pad_out;
    assign o_pad_oe     = pad.pad_oe;
    assign o_pad_pue    = pad.pad_pue;
    assign o_pad_ibe    = pad.pad_ibe;
    assign o_port_rd    = pad.port_rd;
    assign o_analog_sel = analog_sel_q;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // The port input view is the gated value, so software sees the same
    // zeros that the port logic sees on analog pins.
    always_comb begin
        rdata_d = apc_pkg::APC_RDATA_NONE;
        if (i_rd) begin
            unique case (i_addr)
                apc_pkg::APC_OFS_DISABLE_CH0_7: begin
                    rdata_d = dis_ch0_7_q;
                end
                apc_pkg::APC_OFS_DISABLE_CH8_15: begin
                    rdata_d = dis_ch8_15_q;
                end
                apc_pkg::APC_OFS_DISABLE_CH16_23: begin
                    rdata_d = dis_ch16_23_q;
                end
                apc_pkg::APC_OFS_PORT_IN_CH0_7: begin
                    rdata_d = pad.port_rd[apc_pkg::APC_CH_BASE_REG0 +:
                                          apc_pkg::APC_REG_W];
                end
                apc_pkg::APC_OFS_PORT_IN_CH8_15: begin
                    rdata_d = pad.port_rd[apc_pkg::APC_CH_BASE_REG1 +:
                                          apc_pkg::APC_REG_W];
                end
                apc_pkg::APC_OFS_PORT_IN_CH16_23: begin
                    rdata_d = pad.port_rd[apc_pkg::APC_CH_BASE_REG2 +:
                                          apc_pkg::APC_REG_W];
                end
                default: begin
                    rdata_d = apc_pkg::APC_RDATA_NONE;
                end
            endcase
        end
    end

    // Read data stand for exactly the cycle after the strobe and return
    // to zero otherwise.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_q <= apc_pkg::APC_RDATA_NONE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

endmodule // apc_pin_ctrl

// file: core/apc_pkg.sv
// Purpose: Shared constants for the analog pin control block.
// Assumes: Eight-bit register port, one system clock, 24 channels.
// Notes:   Offsets are register indices on the plain register port.

package apc_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int unsigned APC_REG_W    = 8;
    localparam int unsigned APC_NUM_REGS = 3;
    localparam int unsigned APC_NUM_CH   = APC_REG_W * APC_NUM_REGS;
    localparam int unsigned APC_ADDR_W   = 3;

    typedef logic [APC_REG_W-1:0]  apc_byte_t;
    typedef logic [APC_NUM_CH-1:0] apc_chan_t;
    typedef logic [APC_ADDR_W-1:0] apc_addr_t;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam apc_addr_t APC_OFS_DISABLE_CH0_7   = 3'h0;
    localparam apc_addr_t APC_OFS_DISABLE_CH8_15  = 3'h1;
    localparam apc_addr_t APC_OFS_DISABLE_CH16_23 = 3'h2;
    localparam apc_addr_t APC_OFS_PORT_IN_CH0_7   = 3'h3;
    localparam apc_addr_t APC_OFS_PORT_IN_CH8_15  = 3'h4;
    localparam apc_addr_t APC_OFS_PORT_IN_CH16_23 = 3'h5;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned APC_CH_BASE_REG0 = 0;
    localparam int unsigned APC_CH_BASE_REG1 = 8;
    localparam int unsigned APC_CH_BASE_REG2 = 16;

    localparam apc_byte_t APC_RST_DISABLE = 8'h00;
    localparam apc_byte_t APC_RDATA_NONE  = 8'h00;
    localparam apc_chan_t APC_RST_CHAN    = 24'h000000;

endpackage

// file: test/apc_gpio_model.sv
// Purpose: Port logic and pins on the far side of the pin control.
// Assumes: Port settings registered on the system clock.
// Notes:   Pin level is worked out from the gated pad controls.
`timescale 1ns/10ps
module apc_gpio_model (
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    input  wire apc_pkg::apc_chan_t i_out,
    input  wire apc_pkg::apc_chan_t i_oe,
    input  wire apc_pkg::apc_chan_t i_pue,
    input  wire apc_pkg::apc_chan_t i_ext,
    input  wire apc_pkg::apc_chan_t i_pad_out,
    input  wire apc_pkg::apc_chan_t i_pad_oe,
    input  wire apc_pkg::apc_chan_t i_pad_pue,
    output apc_pkg::apc_chan_t      o_port_out,
    output apc_pkg::apc_chan_t      o_port_oe,
    output apc_pkg::apc_chan_t      o_port_pue,
    output apc_pkg::apc_chan_t      o_pad_in
);
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_port_out <= '0;
            o_port_oe  <= '0;
            o_port_pue <= '0;
        end else begin
            o_port_out <= i_out;
            o_port_oe  <= i_oe;
            o_port_pue <= i_pue;
        end
    end
    // An undriven pin without pullup takes the external level, so a
    // masked pin can sit high and still must read zero.
    assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_pad_pue)
                    | (~i_pad_oe & ~i_pad_pue & i_ext);
endmodule // apc_gpio_model

// file: test/apc_pin_ctrl_properties.sv
// Purpose: Port-level checks of the analog pin control block.
// Assumes: One clock, asynchronous active-high reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
module apc_pin_ctrl_properties (
    input wire logic               i_clk,
    input wire logic               i_sys_rst,
    input wire apc_pkg::apc_addr_t i_addr,
    input wire apc_pkg::apc_byte_t i_wdata,
    input wire logic               i_wr,
    input wire logic               i_rd,
    input wire logic [7:0]         o_rdata,
    input wire apc_pkg::apc_chan_t i_port_out,
    input wire apc_pkg::apc_chan_t i_port_oe,
    input wire apc_pkg::apc_chan_t i_port_pue,
    input wire apc_pkg::apc_chan_t i_pad_in,
    input wire apc_pkg::apc_chan_t o_pad_out,
    input wire apc_pkg::apc_chan_t o_pad_oe,
    input wire apc_pkg::apc_chan_t o_pad_pue,
    input wire apc_pkg::apc_chan_t o_pad_ibe,
    input wire apc_pkg::apc_chan_t o_port_rd,
    input wire apc_pkg::apc_chan_t o_analog_sel
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    AST_OE_HIZ: assert property ((o_pad_oe & o_analog_sel) == '0)
        else $error("Masked pin drives its output");
    AST_PULLUP_OFF: assert property ((o_pad_pue & o_analog_sel) == '0)
        else $error("Masked pin keeps its pullup");
    AST_IBUF_OFF: assert property (o_pad_ibe == ~o_analog_sel)
        else $error("Input buffer enable disagrees with mask");
    AST_READ_ZERO: assert property ((o_port_rd & o_analog_sel) == '0)
        else $error("Masked pin reads nonzero");
    // The first edge after reset still sees inputs sampled during reset.
    AST_OE_FOLLOW: assert property (!$past(i_sys_rst) |->
        o_pad_oe == ($past(i_port_oe) & ~o_analog_sel))
        else $error("Output enable does not follow the port");
    AST_PUE_FOLLOW: assert property (!$past(i_sys_rst) |->
        o_pad_pue == ($past(i_port_pue) & ~o_analog_sel))
        else $error("Pullup enable does not follow the port");
    AST_WR_CH0_7: assert property (i_wr && i_addr == 3'h0 |->
        ##2 o_analog_sel[7:0] == $past(i_wdata, 2))
        else $error("Channels 0-7 select wrong");
    AST_WR_CH8_15: assert property (i_wr && i_addr == 3'h1 |->
        ##2 o_analog_sel[15:8] == $past(i_wdata, 2))
        else $error("Channels 8-15 select wrong");
    AST_WR_CH16_23: assert property (i_wr && i_addr == 3'h2 |->
        ##2 o_analog_sel[23:16] == $past(i_wdata, 2))
        else $error("Channels 16-23 select wrong");
    AST_RST_CLEAR: assert property ($past(i_sys_rst) |->
        o_analog_sel == '0)
        else $error("Select not clear after reset");
    cover property (i_wr && i_addr == 3'h2);
    cover property ((o_analog_sel & i_port_oe) != '0);
    cover property ($past(i_rd) && o_rdata != 8'h00);
endmodule // apc_pin_ctrl_properties

bind apc_pin_ctrl apc_pin_ctrl_properties chk_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_port_out(i_port_out), .i_port_oe(i_port_oe),
    .i_port_pue(i_port_pue), .i_pad_in(i_pad_in), .o_pad_out(o_pad_out),
    .o_pad_oe(o_pad_oe), .o_pad_pue(o_pad_pue), .o_pad_ibe(o_pad_ibe),
    .o_port_rd(o_port_rd), .o_analog_sel(o_analog_sel));

// file: test/tb_adc_analog_pin_control.sv
// Purpose: Self-checking bench for the analog pin control block.
// Assumes: 20 MHz clock, reset held 16 cycles.
// Notes:   Register access through the plain strobe port.
`timescale 1ns/10ps
module tb_adc_analog_pin_control;
    logic               i_clk = 1'b0;
    logic               i_sys_rst, i_wr, i_rd;
    apc_pkg::apc_addr_t i_addr;
    apc_pkg::apc_byte_t i_wdata;
    logic [7:0]         o_rdata;
    apc_pkg::apc_chan_t p_out, p_oe, p_pue, pad_in, w_out, w_oe, w_pue;
    apc_pkg::apc_chan_t ext, g_out, g_oe, g_pue, g_ibe, p_rd, sel, mask;
    int                 err_count = 0, n_tests = 0, cyc = 0;

    always #25 i_clk = ~i_clk;

    apc_pin_ctrl dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_port_out(p_out), .i_port_oe(p_oe),
        .i_port_pue(p_pue), .i_pad_in(pad_in), .o_pad_out(g_out),
        .o_pad_oe(g_oe), .o_pad_pue(g_pue), .o_pad_ibe(g_ibe),
        .o_port_rd(p_rd), .o_analog_sel(sel));
    apc_gpio_model gpio_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_out(w_out), .i_oe(w_oe), .i_pue(w_pue), .i_ext(ext),
        .i_pad_out(g_out), .i_pad_oe(g_oe), .i_pad_pue(g_pue),
        .o_port_out(p_out), .o_port_oe(p_oe), .o_port_pue(p_pue),
        .o_pad_in(pad_in));

    task automatic check(input string nm, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input apc_pkg::apc_addr_t a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdchk(input apc_pkg::apc_addr_t a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check("rdata", {16'h0000, o_rdata}, {16'h0000, e});
    endtask
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic pads;
        repeat (6) @(posedge i_clk);
        #1;
        check("sel", sel, mask);
        check("oe", g_oe, w_oe & ~mask);
        check("pue", g_pue, w_pue & ~mask);
        check("out", g_out, w_out & ~mask);
        check("ibe", g_ibe, ~mask);
        check("prd", p_rd, ~mask);
        for (int r = 0; r < 3; r++)
            rdchk(r[2:0] + 3'h3, ~mask[8*r +: 8]);
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            test_done();
        end
    end

    initial begin
        i_sys_rst = 1'b1;
        {i_wr, i_rd, i_addr, i_wdata} = '0;
        {w_out, w_oe, w_pue} = '0;
        ext = '1;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        check("sel_rst", sel, '0);
        check("ibe_rst", g_ibe, '1);
        for (int r = 0; r < 3; r++)
            rdchk(r[2:0], 8'h00);
        $display("Test reset done");
        w_out <= '1;
        w_oe  <= '1;
        w_pue <= '1;
        mask = '0;
        pads();
        mask = 24'h018081;
        for (int r = 0; r < 3; r++)
            wr(r[2:0], mask[8*r +: 8]);
        for (int r = 0; r < 3; r++)
            rdchk(r[2:0], mask[8*r +: 8]);
        pads();
        $display("Test mask done");
        w_oe <= 24'hff00ff;
        wr(3'h1, 8'h00);
        mask = 24'h010081;
        pads();
        wr(3'h6, 8'hff);
        rdchk(3'h6, 8'h00);
        rdchk(3'h1, 8'h00);
        $display("Test release done");
        // A reset in mid-run must drop the masks that are still set.
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        mask = '0;
        pads();
        for (int r = 0; r < 3; r++)
            rdchk(r[2:0], 8'h00);
        $display("Test mid-run reset done");
        test_done();
    end
endmodule // tb_adc_analog_pin_control
